/* File: pkg/stack_unit_pkg.sv */
/*
 * Shared constants and types of the procedure call stack unit.
 * Assumes one core clock; included by the design file as stack_unit_pkg::name.
 */
package stack_unit_pkg;

	// ==========================================================
	// Operation codes of the command port
	typedef enum logic [3:0] {
		OP_CALL_NEAR,
		OP_CALL_FAR,
		OP_RET_NEAR,
		OP_RET_FAR,
		OP_SAVE_ALL,
		OP_RESTORE_ALL,
		OP_SAVE_FLAGS_WORD,
		OP_SAVE_FLAGS_FULL,
		OP_LOAD_FLAGS_WORD,
		OP_LOAD_FLAGS_FULL,
		OP_SEG_PUSH,
		OP_EXTRA_SEG_POP,
		OP_FAR_PTR_LOAD
	} op_t;

	// ==========================================================
	// Widths
	localparam int XLEN = 64;
	localparam int SEL_W = 16;
	localparam int FLAGS_W = 32;
	localparam int REG_ADDR_W = 4;
	localparam int PRIV_W = 2;

	// ==========================================================
	// Item sizes in bytes
	localparam logic [3:0] BYTES_WORD = 4'h2;
	localparam logic [3:0] BYTES_DWORD = 4'h4;
	localparam logic [3:0] BYTES_QWORD = 4'h8;

	// ==========================================================
	// General register slots, save-all order is slot 0 upward
	localparam logic [2:0] GPR_LAST = 3'h7;
	localparam logic [2:0] GPR_SLOT_SP = 3'h4;
	localparam logic [2:0] GPR_SLOT_FP = 3'h5;

	// ==========================================================
	// Register port map (0..7 are the general registers)
	localparam logic [3:0] REG_INSTR_PTR = 4'h8;
	localparam logic [3:0] REG_FLAGS = 4'h9;
	localparam logic [3:0] REG_CODE_SEL = 4'ha;
	localparam logic [3:0] REG_EXTRA_SEL = 4'hb;
	localparam logic [3:0] REG_STATUS = 4'hc;

	// ==========================================================
	// Reset values
	localparam logic [63:0] RST_WORD64 = 64'h0;
	localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
	localparam logic [15:0] RST_SEL = 16'h0;

endpackage : stack_unit_pkg

/* File: design/procedure_call_stack_unit.sv */
/*
 * Procedure linking and stack engine: calls, returns, save-all, flags save
 * and restore, 64-bit stack rules.
 * Assumes a stack memory that takes a request per cycle and returns read
 * data in the cycle after the request is shown.
 */
// Decided for this implementation: the address map and the strobed register port.
// What this block does
// - Near call pushes instruction pointer, then loads target offset, then runs.
// - Near return pops instruction pointer, releases optional bytes, resumes caller.
// - Far call pushes code selector, then instruction pointer, then loads both targets.
// - Far return pops instruction pointer, then code selector, then releases bytes.
// - Return byte count is added to the stack pointer after the pops.
// - Frame-pointer based references default to the stack segment.
// - Return pops whatever sits at the current stack pointer, no tracking.
// - Popped return address is never checked against the caller.
// - Calls push only return linkage, no registers or flags.
// - In 64-bit mode stack addresses use a zero base.
// - In 64-bit mode stack descriptor privilege is forced to current privilege.
// - In 64-bit mode stack, instruction and frame pointers are 64 bits wide.
// - In 64-bit mode far data pointer load and extra segment pop are invalid.
// - In 64-bit mode pushes and pops step by eight bytes, word flags pushes and pops by two.
// - Segment selector pushes keep the stack pointer stepping by full stack width.
// - Save-all pushes eight registers in fixed order, with pre-instruction stack pointer.
// - Restore-all pops in reverse order and discards the saved stack pointer.
// - Word flags push stores low flags word, full push stores all.
// - Word flags pop loads low word, full pop loads whole flags.
// - Each return form pops exactly the linkage its matching call pushed.
// - Push decrements then writes; pop reads then increments.
// - Outside 64-bit mode, steps are two or four bytes by stack width; word flags take two and full flags four.
`timescale 1ns/1ns
`default_nettype none

module procedure_call_stack_unit (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Command port
	input wire logic cmdStart,
	input wire stack_unit_pkg::op_t cmdOp,
	input wire logic [63:0] cmdTargetOffset,
	input wire logic [15:0] cmdTargetSel,
	input wire logic [15:0] cmdReleaseBytes,
	output logic cmdBusy,
	output logic cmdDone,
	output logic invalidOp,
	// Mode and stack descriptor
	input wire logic mode64,
	input wire logic stackWide32,
	input wire logic [1:0] currentPrivLevel,
	input wire logic ssLoad,
	input wire logic [63:0] ssLoadBase,
	input wire logic [1:0] ssLoadPriv,
	output logic [1:0] stackDescPriv,
	// Default segment lookup
	input wire logic refUsesFrame,
	input wire logic refUsesStack,
	output logic refDefaultStack,
	// Stack memory
	output logic memReq,
	output logic memWe,
	output logic memStackSeg,
	output logic [63:0] memAddr,
	output logic [63:0] memWData,
	output logic [3:0] memBytes,
	input wire logic [63:0] memRData,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [63:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [63:0] regRData,
	// Pointer views
	output logic [63:0] wideInstrPointer,
	output logic [63:0] wideStackPointer,
	output logic [63:0] wideFramePointer,
	output logic [31:0] instrPointer,
	output logic [31:0] stackPointer,
	output logic [31:0] framePointer
);

	// ==========================================================
	// State
	typedef enum logic [2:0] {
		ST_IDLE, ST_PUSH, ST_POP_RD, ST_POP_WT, ST_POP_LD, ST_RELEASE, ST_FINISH
	} state_t;

	state_t state_r, state_nxt;
	stack_unit_pkg::op_t op_r;
	logic [63:0] gpr_r [0:7];
	logic [63:0] gpr_nxt [0:7];
	logic [63:0] ip_r, ip_nxt;
	logic [31:0] flags_r, flags_nxt;
	logic [15:0] codeSel_r, codeSel_nxt;
	logic [15:0] extraSel_r, extraSel_nxt;
	logic [63:0] tgtOff_r;
	logic [15:0] tgtSel_r;
	logic [15:0] relBytes_r;
	logic [63:0] spStart_r;
	logic [63:0] ssBase_r;
	logic [1:0] ssPriv_r;
	logic [2:0] idx_r, idx_nxt;
	logic memReq_r, memWe_r, done_r, invalid_r;
	logic [63:0] memAddr_r, memWData_r, regRData_r;
	logic [3:0] memBytes_r;
	logic [63:0] readMux;

	// ==========================================================
	// Decode of the command and of the stack geometry
	wire logic [63:0] sp = gpr_r[stack_unit_pkg::GPR_SLOT_SP];
	wire logic stackWide = mode64 | stackWide32;
	wire logic badIn64 = mode64 & ((cmdOp == stack_unit_pkg::OP_FAR_PTR_LOAD) |
		(cmdOp == stack_unit_pkg::OP_EXTRA_SEG_POP));
	wire logic startOk = ce & cmdStart & (state_r == ST_IDLE);
	wire logic isCall = (op_r == stack_unit_pkg::OP_CALL_NEAR) |
		(op_r == stack_unit_pkg::OP_CALL_FAR);
	wire logic isRet = (op_r == stack_unit_pkg::OP_RET_NEAR) |
		(op_r == stack_unit_pkg::OP_RET_FAR);
	wire logic opIsPush = (cmdOp == stack_unit_pkg::OP_CALL_NEAR) |
		(cmdOp == stack_unit_pkg::OP_CALL_FAR) | (cmdOp == stack_unit_pkg::OP_SAVE_ALL) |
		(cmdOp == stack_unit_pkg::OP_SAVE_FLAGS_WORD) |
		(cmdOp == stack_unit_pkg::OP_SAVE_FLAGS_FULL) | (cmdOp == stack_unit_pkg::OP_SEG_PUSH);
	wire logic opIsPop = (cmdOp == stack_unit_pkg::OP_RET_NEAR) |
		(cmdOp == stack_unit_pkg::OP_RET_FAR) | (cmdOp == stack_unit_pkg::OP_RESTORE_ALL) |
		(cmdOp == stack_unit_pkg::OP_LOAD_FLAGS_WORD) |
		(cmdOp == stack_unit_pkg::OP_LOAD_FLAGS_FULL) |
		(cmdOp == stack_unit_pkg::OP_EXTRA_SEG_POP);
	wire logic isWordFlags = (op_r == stack_unit_pkg::OP_SAVE_FLAGS_WORD) |
		(op_r == stack_unit_pkg::OP_LOAD_FLAGS_WORD);
	wire logic isFullFlags = (op_r == stack_unit_pkg::OP_SAVE_FLAGS_FULL) |
		(op_r == stack_unit_pkg::OP_LOAD_FLAGS_FULL);

	// Stack step by mode and width, selectors take the full step
	wire logic [3:0] stepBytes = mode64 ? stack_unit_pkg::BYTES_QWORD :
		(stackWide32 ? stack_unit_pkg::BYTES_DWORD : stack_unit_pkg::BYTES_WORD);
	wire logic [3:0] itemBytes = isWordFlags ? stack_unit_pkg::BYTES_WORD :
		((isFullFlags & !mode64) ? stack_unit_pkg::BYTES_DWORD : stepBytes);
	wire logic [63:0] itemDelta = {60'h0, itemBytes};

	// Pre-decrement for push, post-increment for pop, 16-bit stacks wrap in SP
	wire logic [63:0] pushSum = sp - itemDelta;
	wire logic [63:0] popSum = sp + itemDelta;
	wire logic [63:0] relSum = sp + {48'h0, relBytes_r};
	wire logic [63:0] pushSp = stackWide ? pushSum : {sp[63:16], pushSum[15:0]};
	wire logic [63:0] popSp = stackWide ? popSum : {sp[63:16], popSum[15:0]};
	wire logic [63:0] relSp = stackWide ? relSum : {sp[63:16], relSum[15:0]};

	// Address through the stack segment, zero base in 64-bit mode
	wire logic [63:0] stackBase = mode64 ? 64'h0 : ssBase_r;
	wire logic [63:0] pushAddr = stackBase + (stackWide ? pushSp : {48'h0, pushSp[15:0]});
	wire logic [63:0] popAddr = stackBase + (stackWide ? sp : {48'h0, sp[15:0]});

	// Items in the sequence, minus one
	wire logic [2:0] lastIdx = ((op_r == stack_unit_pkg::OP_SAVE_ALL) |
		(op_r == stack_unit_pkg::OP_RESTORE_ALL)) ? stack_unit_pkg::GPR_LAST :
		((op_r == stack_unit_pkg::OP_CALL_FAR) | (op_r == stack_unit_pkg::OP_RET_FAR)) ?
		3'h1 : 3'h0;
	wire logic lastItem = (idx_r == lastIdx);
	wire logic [2:0] restoreSlot = stack_unit_pkg::GPR_LAST - idx_r;

	// Default segment of a memory reference
	assign refDefaultStack = refUsesFrame | refUsesStack;

	// ==========================================================
	// Value of the item being pushed
	logic [63:0] pushValue;
	always_comb begin
		pushValue = 64'h0;
		unique case (op_r)
			stack_unit_pkg::OP_CALL_NEAR: pushValue = ip_r;
			stack_unit_pkg::OP_CALL_FAR: pushValue = (idx_r == 3'h0) ?
				{48'h0, codeSel_r} : ip_r;
			stack_unit_pkg::OP_SAVE_ALL: pushValue = (idx_r == stack_unit_pkg::GPR_SLOT_SP) ?
				spStart_r : gpr_r[idx_r];
			stack_unit_pkg::OP_SAVE_FLAGS_WORD: pushValue = {48'h0, flags_r[15:0]};
			stack_unit_pkg::OP_SAVE_FLAGS_FULL: pushValue = {32'h0, flags_r};
			stack_unit_pkg::OP_SEG_PUSH: pushValue = {48'h0, extraSel_r};
			default: pushValue = 64'h0;
		endcase
	end

	// ==========================================================
	// Sequencer and register next values
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		ip_nxt = ip_r;
		flags_nxt = flags_r;
		codeSel_nxt = codeSel_r;
		extraSel_nxt = extraSel_r;
		for (int i = 0; i < 8; i++) begin
			gpr_nxt[i] = gpr_r[i];
		end
		unique case (state_r)
			ST_IDLE: begin
				idx_nxt = 3'h0;
				if (cmdStart && !badIn64) begin
					state_nxt = opIsPush ? ST_PUSH : (opIsPop ? ST_POP_RD : ST_FINISH);
				end else if (regWr && !cmdStart) begin
					if (!regAddr[3]) begin
						gpr_nxt[regAddr[2:0]] = regWData;
					end else if (regAddr == stack_unit_pkg::REG_INSTR_PTR) begin
						ip_nxt = regWData;
					end else if (regAddr == stack_unit_pkg::REG_FLAGS) begin
						flags_nxt = regWData[31:0];
					end else if (regAddr == stack_unit_pkg::REG_CODE_SEL) begin
						codeSel_nxt = regWData[15:0];
					end else if (regAddr == stack_unit_pkg::REG_EXTRA_SEL) begin
						extraSel_nxt = regWData[15:0];
					end
				end
			end
			ST_PUSH: begin
				gpr_nxt[stack_unit_pkg::GPR_SLOT_SP] = pushSp;
				idx_nxt = idx_r + 3'h1;
				state_nxt = lastItem ? ST_FINISH : ST_PUSH;
			end
			ST_POP_RD: state_nxt = ST_POP_WT;
			ST_POP_WT: state_nxt = ST_POP_LD;
			ST_POP_LD: begin
				gpr_nxt[stack_unit_pkg::GPR_SLOT_SP] = popSp;
				unique case (op_r)
					stack_unit_pkg::OP_RET_NEAR: ip_nxt = memRData;
					stack_unit_pkg::OP_RET_FAR: begin
						if (idx_r == 3'h0) begin
							ip_nxt = memRData;
						end else begin
							codeSel_nxt = memRData[15:0];
						end
					end
					stack_unit_pkg::OP_RESTORE_ALL: begin
						if (restoreSlot != stack_unit_pkg::GPR_SLOT_SP) begin
							gpr_nxt[restoreSlot] = memRData;
						end
					end
					stack_unit_pkg::OP_LOAD_FLAGS_WORD: flags_nxt[15:0] = memRData[15:0];
					stack_unit_pkg::OP_LOAD_FLAGS_FULL: flags_nxt = memRData[31:0];
					stack_unit_pkg::OP_EXTRA_SEG_POP: extraSel_nxt = memRData[15:0];
					default: ip_nxt = ip_r;
				endcase
				idx_nxt = idx_r + 3'h1;
				state_nxt = !lastItem ? ST_POP_RD : (isRet ? ST_RELEASE : ST_FINISH);
			end
			ST_RELEASE: begin
				gpr_nxt[stack_unit_pkg::GPR_SLOT_SP] = relSp;
				state_nxt = ST_FINISH;
			end
			ST_FINISH: begin
				if (isCall) begin
					ip_nxt = tgtOff_r;
				end
				if (op_r == stack_unit_pkg::OP_CALL_FAR) begin
					codeSel_nxt = tgtSel_r;
				end
				state_nxt = ST_IDLE;
			end
		endcase
		if (!mode64) begin
			ip_nxt[63:32] = 32'h0;
		end
	end

	// ==========================================================
	// Sequencer registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			idx_r <= 3'h0;
		end else if (ce) begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Architectural registers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 8; i++) begin
				gpr_r[i] <= stack_unit_pkg::RST_WORD64;
			end
			ip_r <= stack_unit_pkg::RST_WORD64;
			flags_r <= stack_unit_pkg::RST_FLAGS;
			codeSel_r <= stack_unit_pkg::RST_SEL;
			extraSel_r <= stack_unit_pkg::RST_SEL;
		end else if (ce) begin
			gpr_r <= gpr_nxt;
			ip_r <= ip_nxt;
			flags_r <= flags_nxt;
			codeSel_r <= codeSel_nxt;
			extraSel_r <= extraSel_nxt;
		end
	end

	// Command latch taken at the start
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_r <= stack_unit_pkg::OP_CALL_NEAR;
			tgtOff_r <= stack_unit_pkg::RST_WORD64;
			tgtSel_r <= stack_unit_pkg::RST_SEL;
			relBytes_r <= 16'h0;
			spStart_r <= stack_unit_pkg::RST_WORD64;
		end else if (startOk) begin
			op_r <= cmdOp;
			tgtOff_r <= cmdTargetOffset;
			tgtSel_r <= cmdTargetSel;
			relBytes_r <= cmdReleaseBytes;
			spStart_r <= sp;
		end
	end

	// Stack descriptor, privilege forced in 64-bit mode
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ssBase_r <= stack_unit_pkg::RST_WORD64;
			ssPriv_r <= 2'h0;
		end else if (ce && ssLoad) begin
			ssBase_r <= ssLoadBase;
			ssPriv_r <= mode64 ? currentPrivLevel : ssLoadPriv;
		end else if (ce && mode64) begin
			ssPriv_r <= currentPrivLevel;
		end
	end

	// Memory request, one cycle per item
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			memReq_r <= 1'b0;
			memWe_r <= 1'b0;
			memAddr_r <= 64'h0;
			memWData_r <= 64'h0;
			memBytes_r <= 4'h0;
		end else if (ce) begin
			memReq_r <= (state_r == ST_PUSH) | (state_r == ST_POP_RD);
			memWe_r <= (state_r == ST_PUSH);
			if (state_r == ST_PUSH) begin
				memAddr_r <= pushAddr;
				memWData_r <= pushValue;
				memBytes_r <= itemBytes;
			end else if (state_r == ST_POP_RD) begin
				memAddr_r <= popAddr;
				memBytes_r <= itemBytes;
			end
		end
	end

	// Status pulses and register readback
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_r <= 1'b0;
			invalid_r <= 1'b0;
			regRData_r <= 64'h0;
		end else if (ce) begin
			done_r <= (state_r == ST_FINISH);
			invalid_r <= startOk & badIn64;
			regRData_r <= regRd ? readMux : 64'h0;
		end
	end

	// ==========================================================
	// Readback selection
	assign readMux = !regAddr[3] ? gpr_r[regAddr[2:0]] :
		(regAddr == stack_unit_pkg::REG_INSTR_PTR) ? ip_r :
		(regAddr == stack_unit_pkg::REG_FLAGS) ? {32'h0, flags_r} :
		(regAddr == stack_unit_pkg::REG_CODE_SEL) ? {48'h0, codeSel_r} :
		(regAddr == stack_unit_pkg::REG_EXTRA_SEL) ? {48'h0, extraSel_r} :
		(regAddr == stack_unit_pkg::REG_STATUS) ?
		{59'h0, ssPriv_r, mode64, stackWide32, cmdBusy} : 64'h0;

	// Outputs
	assign cmdBusy = (state_r != ST_IDLE);
	assign cmdDone = done_r;
	assign invalidOp = invalid_r;
	assign stackDescPriv = ssPriv_r;
	assign memReq = memReq_r;
	assign memWe = memWe_r;
	assign memStackSeg = 1'b1;
	assign memAddr = memAddr_r;
	assign memWData = memWData_r;
	assign memBytes = memBytes_r;
	assign regRData = regRData_r;
	assign wideInstrPointer = ip_r;
	assign wideStackPointer = sp;
	assign wideFramePointer = gpr_r[stack_unit_pkg::GPR_SLOT_FP];
	assign instrPointer = ip_r[31:0];
	assign stackPointer = sp[31:0];
	assign framePointer = gpr_r[stack_unit_pkg::GPR_SLOT_FP][31:0];

	// ==========================================================
	// Checks
	sequence s_nearCallStart;
		startOk && !badIn64 && cmdOp == stack_unit_pkg::OP_CALL_NEAR;
	endsequence

	sequence s_linkWritten;
		memReq && memWe && memWData == $past(ip_r, 2);
	endsequence

	a_near_call_seq: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		s_nearCallStart |-> ##2 s_linkWritten ##1 (cmdDone && ip_r == tgtOff_r))
		else $error("near call did not push link then load target");

	a_push_predec: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_PUSH |=> memWe && memAddr == stackBase + (stackWide ? sp :
		{48'h0, sp[15:0]}) && sp == $past(sp) - {60'h0, $past(itemBytes)})
		else $error("push did not pre-decrement and write at new top");

	a_pop_postinc: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_POP_LD && stackWide |=> sp == $past(sp) + {60'h0, $past(itemBytes)})
		else $error("pop did not post-increment stack pointer");

	a_release_bytes: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_RELEASE && stackWide |=> sp == $past(sp) + {48'h0, $past(relBytes_r)}
		##1 cmdDone)
		else $error("return did not release parameter bytes");

	a_invalid_64: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		startOk && badIn64 |=> invalidOp && state_r == ST_IDLE && !memReq)
		else $error("invalid 64-bit segment load was executed");

	a_priv_forced: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		mode64 && ssLoad |=> stackDescPriv == $past(currentPrivLevel))
		else $error("stack privilege not forced to current level");

	a_step_64: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		memReq && mode64 && !isWordFlags |-> memBytes == stack_unit_pkg::BYTES_QWORD)
		else $error("64-bit stack access not eight bytes");

	a_zero_base: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_POP_RD && mode64 |=> memReq && memAddr == $past(sp))
		else $error("64-bit stack address used a segment base");

	a_flags_word: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_POP_LD && op_r == stack_unit_pkg::OP_LOAD_FLAGS_WORD |=>
		flags_r == {$past(flags_r[31:16]), $past(memRData[15:0])})
		else $error("word flags pop touched upper flags");

	a_restore_skip: assert property (@(posedge core_clk) disable iff (sys_rst || !ce)
		state_r == ST_POP_LD && op_r == stack_unit_pkg::OP_RESTORE_ALL &&
		restoreSlot == stack_unit_pkg::GPR_SLOT_SP && stackWide |=>
		sp == $past(sp) + {60'h0, $past(itemBytes)})
		else $error("restore-all loaded the saved stack pointer");

endmodule : procedure_call_stack_unit

`default_nettype wire

/* File: tb/stack_mem_model.sv */
/*
 * Stack memory model for the procedure call stack unit.
 * Assumes one request per cycle; read data stand only in the cycle after a read.
 */
`timescale 1ns/1ns
`default_nettype none
module stack_mem_model (
	// Clock
	input wire logic core_clk,
	// Request side
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [63:0] memAddr,
	input wire logic [63:0] memWData,
	// Answer side
	output logic [63:0] memRData
);
	logic [63:0] store [logic [63:0]];
	initial memRData = 64'h0;
	// ==========================================================
	// Stores writes, answers reads once, scrambles the bus otherwise
	always @(posedge core_clk) begin
		if (memReq && memWe) store[memAddr] = memWData;
		if (memReq && !memWe) memRData <= store.exists(memAddr) ? store[memAddr] : 64'h0;
		else memRData <= ~memRData;
	end
endmodule : stack_mem_model
`default_nettype wire

/* File: tb/testbench.sv */
/*
 * Self-checking bench of the procedure call stack unit.
 * Assumes the stack memory model beside it and a 100 MHz core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// ==========================================================
	// Signals
	logic core_clk = 1'b0, sys_rst = 1'b1, cmdStart = 1'b0, mode64 = 1'b0, stackWide32 = 1'b0;
	logic ssLoad = 1'b0, refUsesFrame = 1'b0, refUsesStack = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic cmdBusy, cmdDone, invalidOp, refDefaultStack, memReq, memWe, memStackSeg;
	logic rdPend = 1'b0;
	logic ce = 1'b1;
	logic [63:0] wideIp, wideSp, wideFp;
	logic [31:0] ip32, sp32, fp32;
	logic [1:0] currentPrivLevel = 2'h3, ssLoadPriv = 2'h1, stackDescPriv;
	logic [3:0] regAddr = 4'h0, memBytes;
	logic [15:0] cmdTargetSel = 16'h0, cmdReleaseBytes = 16'h0;
	logic [63:0] cmdTargetOffset = 64'h0, ssLoadBase = 64'h0, regWData = 64'h0;
	logic [63:0] memAddr, memWData, memRData, regRData;
	stack_unit_pkg::op_t cmdOp = stack_unit_pkg::OP_CALL_NEAR;
	logic [132:0] mq[$];
	logic [63:0] rq[$];
	int err_count = 0, n_tests = 0;
	// Core clock
	always #5 core_clk = ~core_clk;
	procedure_call_stack_unit dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
		.cmdStart(cmdStart), .cmdOp(cmdOp), .cmdTargetOffset(cmdTargetOffset),
		.cmdTargetSel(cmdTargetSel), .cmdReleaseBytes(cmdReleaseBytes), .cmdBusy(cmdBusy),
		.cmdDone(cmdDone), .invalidOp(invalidOp), .mode64(mode64), .stackWide32(stackWide32),
		.currentPrivLevel(currentPrivLevel), .ssLoad(ssLoad), .ssLoadBase(ssLoadBase),
		.ssLoadPriv(ssLoadPriv), .stackDescPriv(stackDescPriv), .refUsesFrame(refUsesFrame),
		.refUsesStack(refUsesStack), .refDefaultStack(refDefaultStack), .memReq(memReq),
		.memWe(memWe), .memStackSeg(memStackSeg), .memAddr(memAddr), .memWData(memWData),
		.memBytes(memBytes), .memRData(memRData), .regAddr(regAddr), .regWData(regWData),
		.regWr(regWr), .regRd(regRd), .regRData(regRData), .wideInstrPointer(wideIp),
		.wideStackPointer(wideSp), .wideFramePointer(wideFp), .instrPointer(ip32),
		.stackPointer(sp32), .framePointer(fp32));
	stack_mem_model mem_u (.core_clk(core_clk), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWData(memWData), .memRData(memRData));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [132:0] got, input logic [132:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic ew(input logic we, input logic [3:0] nb, input logic [63:0] a, input logic [63:0] d);
		mq.push_back({we, nb, a, we ? d : 64'h0});
	endtask : ew
	task automatic wr(input logic [3:0] a, input logic [63:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [63:0] e);
		rq.push_back(e);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask : rd
	task automatic op(input stack_unit_pkg::op_t o, input logic [63:0] t, input logic [15:0] s,
		input logic [15:0] n, input logic inv);
		@(posedge core_clk);
		cmdOp <= o;
		cmdTargetOffset <= t;
		cmdTargetSel <= s;
		cmdReleaseBytes <= n;
		cmdStart <= 1'b1;
		@(posedge core_clk);
		cmdStart <= 1'b0;
		for (int i = 0; i < 60 && !(cmdDone === 1'b1 || invalidOp === 1'b1); i++) @(posedge core_clk);
		chk({cmdDone, invalidOp, cmdBusy}, inv ? 3'b010 : 3'b100);
	endtask : op
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	// Takes the oldest note off each queue as results appear
	always @(posedge core_clk) begin
		rdPend <= regRd;
		if (rdPend) chk(regRData, rq.size() ? rq.pop_front() : '1);
		if (memReq === 1'b1) begin
			chk(memStackSeg, 1'b1);
			chk({memWe, memBytes, memAddr, memWe ? memWData : 64'h0}, mq.size() ? mq.pop_front() : '1);
		end
	end
	// Watchdog
	initial begin
		#500000;
		err_count++;
		end_sim;
	end
	// ==========================================================
	// Main sequence: each stack width in turn, then refused forms
	initial begin
		logic [63:0] msk, b, S, t, ip0, cs0, f, h;
		logic [63:0] g[8];
		logic [3:0] st, fb;
		int unsigned seed;
		seed = $urandom(72984);
		S = 64'h200;
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(4'h9, stack_unit_pkg::RST_FLAGS);
		// Register write with the clock enable low must be lost
		ce <= 1'b0;
		wr(4'h8, 64'h55);
		ce <= 1'b1;
		rd(4'h8, 64'h0);
		refUsesFrame <= 1'b1;
		@(posedge core_clk);
		chk(refDefaultStack, 1'b1);
		for (int m = 0; m < 3; m++) begin
			mode64 <= (m == 2);
			stackWide32 <= (m == 1);
			ssLoadBase <= 64'h1000;
			ssLoad <= 1'b1;
			@(posedge core_clk);
			ssLoad <= 1'b0;
			st = (m == 0) ? 4'h2 : (m == 1) ? 4'h4 : 4'h8;
			fb = (m == 2) ? 4'h8 : 4'h4;
			msk = (m == 0) ? 64'hffff : (m == 1) ? 64'hffff_ffff : '1;
			b = (m == 2) ? 64'h0 : 64'h1000;
			ip0 = {$urandom, $urandom} & msk;
			t = {$urandom, $urandom} & msk;
			cs0 = {48'h0, 16'($urandom)};
			@(posedge core_clk);
			chk(stackDescPriv, (m == 2) ? 2'h3 : 2'h1);
			wr(4'h8, ip0);
			wr(4'h4, S);
			ew(1'b1, st, b + S - st, ip0);
			op(stack_unit_pkg::OP_CALL_NEAR, t, 16'h0, 16'h0, 1'b0);
			rd(4'h8, t);
			rd(4'h4, S - st);
			chk({wideIp, ip32}, {t, t[31:0]});
			ew(1'b0, st, b + S - st, 64'h0);
			op(stack_unit_pkg::OP_RET_NEAR, 64'h0, 16'h0, 16'h8, 1'b0);
			rd(4'h8, ip0);
			rd(4'h4, S + 8);
			wr(4'ha, cs0);
			wr(4'h4, S);
			ew(1'b1, st, b + S - st, cs0);
			ew(1'b1, st, b + S - 2 * st, ip0);
			op(stack_unit_pkg::OP_CALL_FAR, t, 16'h9a5c, 16'h0, 1'b0);
			rd(4'ha, 64'h9a5c);
			ew(1'b0, st, b + S - 2 * st, 64'h0);
			ew(1'b0, st, b + S - st, 64'h0);
			op(stack_unit_pkg::OP_RET_FAR, 64'h0, 16'h0, 16'h0, 1'b0);
			rd(4'ha, cs0);
			rd(4'h4, S);
			wr(4'hb, cs0);
			ew(1'b1, st, b + S - st, cs0);
			op(stack_unit_pkg::OP_SEG_PUSH, 64'h0, 16'h0, 16'h0, 1'b0);
			if (m != 2) begin
				wr(4'hb, 64'h0);
				ew(1'b0, st, b + S - st, 64'h0);
				op(stack_unit_pkg::OP_EXTRA_SEG_POP, 64'h0, 16'h0, 16'h0, 1'b0);
				rd(4'hb, cs0);
				op(stack_unit_pkg::OP_FAR_PTR_LOAD, 64'h0, 16'h0, 16'h0, 1'b0);
			end
			for (int i = 0; i < 8; i++) begin
				g[i] = (i == 4) ? S : {$urandom, $urandom} & msk;
				wr(4'(i), g[i]);
				ew(1'b1, st, b + S - (i + 1) * st, g[i]);
			end
			op(stack_unit_pkg::OP_SAVE_ALL, 64'h0, 16'h0, 16'h0, 1'b0);
			for (int i = 7; i >= 0; i--) begin
				ew(1'b0, st, b + S - (i + 1) * st, 64'h0);
				if (i != 4) wr(4'(i), 64'h0);
			end
			op(stack_unit_pkg::OP_RESTORE_ALL, 64'h0, 16'h0, 16'h0, 1'b0);
			for (int i = 0; i < 8; i++) rd(4'(i), g[i]);
			chk({wideSp, sp32}, {g[4], g[4][31:0]});
			chk({wideFp, fp32}, {g[5], g[5][31:0]});
			f = {32'h0, $urandom | 32'h2};
			h = {32'h0, $urandom | 32'h2};
			wr(4'h9, f);
			ew(1'b1, 4'h2, b + S - 2, f & 64'hffff);
			op(stack_unit_pkg::OP_SAVE_FLAGS_WORD, 64'h0, 16'h0, 16'h0, 1'b0);
			ew(1'b1, fb, b + S - 2 - fb, f);
			op(stack_unit_pkg::OP_SAVE_FLAGS_FULL, 64'h0, 16'h0, 16'h0, 1'b0);
			wr(4'h9, h);
			ew(1'b0, fb, b + S - 2 - fb, 64'h0);
			op(stack_unit_pkg::OP_LOAD_FLAGS_FULL, 64'h0, 16'h0, 16'h0, 1'b0);
			rd(4'h9, f);
			wr(4'h9, h);
			ew(1'b0, 4'h2, b + S - 2, 64'h0);
			op(stack_unit_pkg::OP_LOAD_FLAGS_WORD, 64'h0, 16'h0, 16'h0, 1'b0);
			rd(4'h9, {h[63:16], f[15:0]});
		end
		op(stack_unit_pkg::OP_FAR_PTR_LOAD, 64'h0, 16'h0, 16'h0, 1'b1);
		op(stack_unit_pkg::OP_EXTRA_SEG_POP, 64'h0, 16'h0, 16'h0, 1'b1);
		rd(4'h4, S);
		repeat (4) @(posedge core_clk);
		chk(mq.size() + rq.size(), 0);
		end_sim;
	end
endmodule : testbench
`default_nettype wire
